// ===== src/spfs_pkg.sv
package spfs_pkg;

  // Pin group widths.
  localparam int IO_W = 16;
  localparam int SHR_W = 43;
  localparam int DED_W = 5;
  localparam int BUSIO_W = 7;
  localparam int BUSIO_LO = 9;
  localparam int SYNC_W = 1 + DED_W + SHR_W + IO_W;
  localparam int STRAP_BIT = SYNC_W - 1;

  // Register byte offsets.
  localparam logic [7:0] ENABLE_OFS = 8'h00;
  localparam logic [7:0] DIR_OFS = 8'h04;
  localparam logic [7:0] OUT_OFS = 8'h08;
  localparam logic [7:0] IN_OFS = 8'h0C;
  localparam logic [7:0] STAT_OFS = 8'h10;

  // Values after reset, and the data read from unmapped offsets.
  localparam logic [15:0] ENABLE_RST = 16'h0000;
  localparam logic [15:0] DIR_RST = 16'h0000;
  localparam logic [15:0] OUT_RST = 16'h0000;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  // Line masks.
  localparam logic [15:0] CLKLINE_MASK = 16'h0006;
  localparam logic [15:0] BUSIO_MASK = 16'hFE00;

  // Clock divide counts.
  localparam int QUARTER_DIV = 4;
  localparam int SIXTH_DIV = 6;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [31:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } spfs_wb_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } spfs_wb_rsp_s;

  typedef struct packed {
    logic [SHR_W-1:0] out;
    logic [SHR_W-1:0] oe;
  } spfs_pins_s;

  // Merges a 32-bit write into a 16-bit register under the byte lanes.
  function automatic logic [15:0] spfs_merge(input logic [15:0] old, input logic [31:0] wdat,
                                             input logic [3:0] sel);
    logic [15:0] res;
    res = old;
    if (sel[0])
    begin
      res[7:0] = wdat[7:0];
    end
    if (sel[1])
    begin
      res[15:8] = wdat[15:8];
    end
    return res;
  endfunction

endpackage

// ===== src/spfs_clk_div.sv
module spfs_clk_div #(
  parameter int DIV = 4
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Divided clock level.
  output logic clk_o
);
  import spfs_pkg::*;

  localparam logic [2:0] HALF_LAST = 3'(DIV / 2 - 1);

  logic [2:0] cnt;
  wire logic wrap = (cnt == HALF_LAST);
  wire logic [2:0] next_cnt = wrap ? 3'h0 : 3'(cnt + 3'h1);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt <= 3'h0;
      clk_o <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      clk_o <= wrap ? ~clk_o : clk_o;
    end
  end

  half_period_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wrap |=> (clk_o != $past(clk_o)) ##1 (clk_o == $past(clk_o)))
    else $error("Divided clock did not toggle on the half period.");

endmodule // spfs_clk_div

// ===== src/spfs_top.sv
// Function
// - Software function changes apply at any time.
// - Strap sampled only at reset, then fixed.
// - Line 1 pin drives quarter-rate clock by default.
// - Line 2 pin drives sixth-rate clock by default.
// - Enable bits read zero after reset.
// - Enable bit one hands pin to I/O.
// - Direction zero input, one output.
// - Lines 9-15 usable only with strap zero.
// - Strap low selects host port, bus disabled.
// - Strap high gives shared pins to bus.
// - Deselected bus dedicated pins held undriven.
//
// Our own choices: the Wishbone slave port and the register addresses.
module spfs_top (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus.
  input wire spfs_pkg::spfs_wb_req_s wb_i,
  output spfs_pkg::spfs_wb_rsp_s wb_o,
  // Bus-interface select strap.
  input wire logic strap_pin_i,
  // General-purpose I/O pads.
  input wire logic [15:0] io_pad_i,
  output logic [15:0] io_pad_out_o,
  output logic [15:0] io_pad_oe_o,
  // Shared host port pads.
  input wire logic [spfs_pkg::SHR_W-1:0] shr_pad_i,
  output spfs_pkg::spfs_pins_s shr_pad_o,
  // Bus-interface dedicated pads.
  input wire logic [spfs_pkg::DED_W-1:0] ded_pad_i,
  output logic [spfs_pkg::DED_W-1:0] ded_pad_out_o,
  output logic [spfs_pkg::DED_W-1:0] ded_pad_oe_o,
  // Host parallel port side.
  input wire spfs_pkg::spfs_pins_s host_drv_i,
  output logic [spfs_pkg::SHR_W-1:0] host_pin_o,
  output logic host_enable_o,
  // Bus-interface peripheral side.
  input wire spfs_pkg::spfs_pins_s bus_drv_i,
  input wire logic [spfs_pkg::BUSIO_W-1:0] bus_io_out_i,
  input wire logic [spfs_pkg::BUSIO_W-1:0] bus_io_oe_i,
  input wire logic [spfs_pkg::DED_W-1:0] bus_ded_out_i,
  input wire logic [spfs_pkg::DED_W-1:0] bus_ded_oe_i,
  output logic [spfs_pkg::SHR_W-1:0] bus_pin_o,
  output logic [spfs_pkg::BUSIO_W-1:0] bus_io_pin_o,
  output logic [spfs_pkg::DED_W-1:0] bus_ded_pin_o,
  output logic bus_enable_o
);
  import spfs_pkg::*;

  // Input synchronisers: three stages and an agreement filter.
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic [SYNC_W-1:0] sync3;
  logic [SYNC_W-1:0] filt;
  wire logic [SYNC_W-1:0] raw_in = {strap_pin_i, ded_pad_i, shr_pad_i, io_pad_i};
  wire logic [SYNC_W-1:0] agree = ~(sync2 ^ sync3);
  wire logic [SYNC_W-1:0] next_filt = (sync3 & agree) | (filt & ~agree);

  always_ff @(posedge clk_i)
  begin
    sync1 <= raw_in;
    sync2 <= sync1;
    sync3 <= sync2;
    filt <= next_filt;
  end

  wire logic [15:0] io_in_f = filt[IO_W-1:0];
  wire logic [SHR_W-1:0] shr_in_f = filt[IO_W+SHR_W-1:IO_W];
  wire logic [DED_W-1:0] ded_in_f = filt[SYNC_W-2:IO_W+SHR_W];

  // Strap latch: follows the filtered strap while reset is held.
  logic bus_sel;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bus_sel <= filt[STRAP_BIT];
    end
  end

  // Divided clocks.
  logic quart_clk;
  logic six_clk;

  spfs_clk_div #(.DIV(QUARTER_DIV)) u_quarter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clk_o(quart_clk)
  );

  spfs_clk_div #(.DIV(SIXTH_DIV)) u_sixth (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clk_o(six_clk)
  );

  // Software registers.
  logic [15:0] io_en;
  logic [15:0] io_dir;
  logic [15:0] io_out;
  logic [15:0] io_in;

  // Bus decode.
  wire logic req = wb_i.cyc & wb_i.stb;
  wire logic [7:0] ofs = wb_i.adr[7:0];
  wire logic hit_en = (ofs == ENABLE_OFS);
  wire logic hit_dir = (ofs == DIR_OFS);
  wire logic hit_out = (ofs == OUT_OFS);
  wire logic hit_in = (ofs == IN_OFS);
  wire logic hit_stat = (ofs == STAT_OFS);
  wire logic wr_go = req & wb_i.we & wb_o.ack;
  wire logic [31:0] rd_data = hit_en ? {16'h0000, io_en} :
                              hit_dir ? {16'h0000, io_dir} :
                              hit_out ? {16'h0000, io_out} :
                              hit_in ? {16'h0000, io_in} :
                              hit_stat ? {31'h0000_0000, bus_sel} : UNMAPPED_DATA;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_o <= '0;
    end
    else
    begin
      wb_o.ack <= req & ~wb_o.ack;
      wb_o.dat <= (req & ~wb_o.ack & ~wb_i.we) ? rd_data : wb_o.dat;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      io_en <= ENABLE_RST;
      io_dir <= DIR_RST;
      io_out <= OUT_RST;
    end
    else if (wr_go)
    begin
      io_en <= hit_en ? spfs_merge(io_en, wb_i.dat, wb_i.sel) : io_en;
      io_dir <= hit_dir ? spfs_merge(io_dir, wb_i.dat, wb_i.sel) : io_dir;
      io_out <= hit_out ? spfs_merge(io_out, wb_i.dat, wb_i.sel) : io_out;
    end
  end

  always_ff @(posedge clk_i)
  begin
    io_in <= io_in_f;
  end

  // Pin selection.
  wire logic [15:0] bus_mask = bus_sel ? BUSIO_MASK : 16'h0000;
  wire logic [15:0] eff_en = io_en & ~bus_mask;
  wire logic [15:0] gp_oe = eff_en & io_dir;
  wire logic [15:0] clk_mask = CLKLINE_MASK & ~io_en;
  wire logic [15:0] clk_vec = {13'h0000, six_clk, quart_clk, 1'b0};
  wire logic [15:0] bus_vec = {bus_io_out_i, 9'h000};
  wire logic [15:0] bus_oe_vec = {bus_io_oe_i, 9'h000};
  wire logic [15:0] next_io_out = (clk_vec & clk_mask) | (bus_vec & bus_mask) | (io_out & gp_oe);
  wire logic [15:0] next_io_oe = clk_mask | (bus_oe_vec & bus_mask) | gp_oe;
  wire spfs_pins_s next_shr = bus_sel ? bus_drv_i : host_drv_i;
  wire logic [DED_W-1:0] next_ded_oe = bus_sel ? bus_ded_oe_i : '0;
  wire logic [DED_W-1:0] next_ded_out = bus_sel ? bus_ded_out_i : '0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      io_pad_out_o <= 16'h0000;
      io_pad_oe_o <= 16'h0000;
      shr_pad_o <= '0;
      ded_pad_out_o <= '0;
      ded_pad_oe_o <= '0;
      host_pin_o <= '0;
      host_enable_o <= 1'b0;
      bus_pin_o <= '0;
      bus_io_pin_o <= '0;
      bus_ded_pin_o <= '0;
      bus_enable_o <= 1'b0;
    end
    else
    begin
      io_pad_out_o <= next_io_out;
      io_pad_oe_o <= next_io_oe;
      shr_pad_o <= next_shr;
      ded_pad_out_o <= next_ded_out;
      ded_pad_oe_o <= next_ded_oe;
      host_pin_o <= bus_sel ? '0 : shr_in_f;
      host_enable_o <= ~bus_sel;
      bus_pin_o <= bus_sel ? shr_in_f : '0;
      bus_io_pin_o <= bus_sel ? io_in_f[15:9] : '0;
      bus_ded_pin_o <= bus_sel ? ded_in_f : '0;
      bus_enable_o <= bus_sel;
    end
  end

  // Checks.
  strap_frozen_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i |=> $stable(bus_sel))
    else $error("Strap selection changed after reset.");

  quarter_clock_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !io_en[1] |=> io_pad_oe_o[1] && (io_pad_out_o[1] == $past(quart_clk)))
    else $error("Line 1 pin is not driving the quarter-rate clock.");

  sixth_clock_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !io_en[2] |=> io_pad_oe_o[2] && (io_pad_out_o[2] == $past(six_clk)))
    else $error("Line 2 pin is not driving the sixth-rate clock.");

  enable_reset_a: assert property (@(posedge clk_i)
    $fell(rst_i) |-> (io_en == 16'h0000) && (io_dir == 16'h0000))
    else $error("Enable bits are not zero after reset.");

  enable_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_go && hit_en && wb_i.sel[0] && wb_i.dat[1]) |=>
    io_en[1] ##1 (io_pad_oe_o[1] == $past(io_dir[1])))
    else $error("Enable write did not take the pin at once.");

  gpio_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (io_en[1] && io_dir[1]) |=> io_pad_oe_o[1] && (io_pad_out_o[1] == $past(io_out[1])))
    else $error("Enabled output line does not drive its value.");

  gpio_input_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (io_en[2] && !io_dir[2]) |=> !io_pad_oe_o[2])
    else $error("Enabled input line is being driven.");

  busio_lock_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_sel |=> ((io_pad_oe_o & BUSIO_MASK) == ($past(bus_oe_vec) & BUSIO_MASK)))
    else $error("Lines 9 to 15 escaped the bus peripheral.");

  host_default_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !bus_sel |=> (shr_pad_o == $past(host_drv_i)) && host_enable_o && !bus_enable_o)
    else $error("Shared pins are not with the host port.");

  bus_shared_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_sel |=> (shr_pad_o == $past(bus_drv_i)) && (host_pin_o == '0))
    else $error("Shared pins are not with the bus peripheral.");

  dedicated_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !bus_sel |=> (ded_pad_oe_o == '0))
    else $error("Dedicated bus pins driven while deselected.");

endmodule // spfs_top

// ===== verification/spfs_board_model.sv
module spfs_board_model (
  // Board choices.
  input wire logic strap_sel_i,
  input wire logic [15:0] ext_val_i,
  input wire logic [15:0] ext_en_i,
  // Device pads.
  input wire logic [15:0] pad_out_i,
  input wire logic [15:0] pad_oe_i,
  output logic strap_pin_o,
  output logic [15:0] pad_lvl_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // The strap pin follows the board's strap choice, which the test may change at any time.
  assign strap_pin_o = strap_sel_i;
  // A pad nobody drives falls to its internal pull-down.
  assign pad_lvl_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_en_i & ext_val_i);
endmodule // spfs_board_model

// ===== verification/spfs_top_test.sv
module spfs_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  import spfs_pkg::*;
  logic clk_i = 0;
  logic rst_i = 1;
  spfs_wb_req_s wb_req = '0;
  spfs_wb_rsp_s wb_rsp;
  logic strap_sel = 0;
  logic strap_pin;
  logic [15:0] ext_lvl = 16'hFE04;
  logic [15:0] pad_lvl, pad_out, pad_oe;
  logic [SHR_W-1:0] shr_lvl = 43'h2_1234_5678;
  logic [SHR_W-1:0] host_pin, bus_pin;
  spfs_pins_s host_drv = {43'h0_1234_5678, 43'h0_0F0F_0F0F};
  spfs_pins_s bus_drv = {43'h0_8765_4321, 43'h0_F0F0_F0F0};
  spfs_pins_s shr_o;
  logic [6:0] bio_out = 7'h2A;
  logic [6:0] bio_oe = 7'h55;
  logic [6:0] bio_pin;
  logic [4:0] ded_lvl = 5'h19;
  logic [4:0] bded_out = 5'h15;
  logic [4:0] bded_oe = 5'h0B;
  logic [4:0] ded_out, ded_oe, bded_pin;
  logic host_en, bus_en;
  logic [31:0] rd;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;

  always #5 clk_i = ~clk_i;

  spfs_board_model board (.strap_sel_i(strap_sel), .ext_val_i(ext_lvl), .ext_en_i(ext_lvl),
    .pad_out_i(pad_out), .pad_oe_i(pad_oe), .strap_pin_o(strap_pin), .pad_lvl_o(pad_lvl));

  spfs_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_req), .wb_o(wb_rsp),
    .strap_pin_i(strap_pin), .io_pad_i(pad_lvl), .io_pad_out_o(pad_out), .io_pad_oe_o(pad_oe),
    .shr_pad_i(shr_lvl), .shr_pad_o(shr_o), .ded_pad_i(ded_lvl), .ded_pad_out_o(ded_out),
    .ded_pad_oe_o(ded_oe), .host_drv_i(host_drv), .host_pin_o(host_pin),
    .host_enable_o(host_en), .bus_drv_i(bus_drv), .bus_io_out_i(bio_out),
    .bus_io_oe_i(bio_oe), .bus_ded_out_i(bded_out), .bus_ded_oe_i(bded_oe),
    .bus_pin_o(bus_pin), .bus_io_pin_o(bio_pin), .bus_ded_pin_o(bded_pin),
    .bus_enable_o(bus_en));

  task automatic complete_run();
    $display("Errors %0d of %0d checks", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
    begin
      $display("== PASSED ==");
    end
    else
    begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_req <= '{1'b1, 1'b1, we, {24'h0, a}, 4'h3, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_rsp.ack !== 1'b1);
    chk(n, 2);
    rd = wb_rsp.dat;
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask

  task automatic toggles(input int line, input int exp);
    int t;
    logic prev;
    t = 0;
    @(posedge clk_i);
    prev = pad_out[line];
    repeat (24)
    begin
      @(posedge clk_i);
      if (pad_out[line] !== prev)
      begin
        t++;
      end
      prev = pad_out[line];
    end
    chk(t, exp);
    chk(pad_oe[line], 1'b1);
  endtask

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      complete_run();
    end
  end

  initial
  begin
    do_reset();
    rd_chk(ENABLE_OFS, 32'h0000_0000);
    rd_chk(DIR_OFS, 32'h0000_0000);
    rd_chk(STAT_OFS, 32'h0000_0000);
    chk({host_en, bus_en}, 2'b10);
    chk(shr_o, host_drv);
    chk({host_pin, bus_pin}, {shr_lvl, 43'h0});
    chk({ded_oe, ded_out, bded_pin, bio_pin}, 22'h00_0000);
    toggles(1, 12);
    toggles(2, 8);
    wb(1'b1, DIR_OFS, 32'h0000_FE02);
    wb(1'b1, OUT_OFS, 32'h0000_AA02);
    wb(1'b1, ENABLE_OFS, 32'h0000_FE06);
    @(posedge clk_i);
    chk(pad_oe, 16'hFE02);
    chk(pad_out & pad_oe, 16'hAA02);
    repeat (6) @(posedge clk_i);
    rd_chk(IN_OFS, 32'h0000_AA06);
    wb(1'b1, IN_OFS, 32'h0000_FFFF);
    rd_chk(IN_OFS, 32'h0000_AA06);
    rd_chk(8'h20, UNMAPPED_DATA);
    wb(1'b1, ENABLE_OFS, 32'h0000_0000);
    toggles(1, 12);
    strap_sel <= 1'b1;
    repeat (8) @(posedge clk_i);
    rd_chk(STAT_OFS, 32'h0000_0000);
    chk({host_en, bus_en}, 2'b10);
    do_reset();
    rd_chk(STAT_OFS, 32'h0000_0001);
    chk({host_en, bus_en}, 2'b01);
    chk(shr_o, bus_drv);
    chk({host_pin, bus_pin}, {43'h0, shr_lvl});
    chk({ded_oe, ded_out & ded_oe, bded_pin}, {bded_oe, bded_out & bded_oe, ded_lvl});
    wb(1'b1, DIR_OFS, 32'h0000_FE00);
    wb(1'b1, ENABLE_OFS, 32'h0000_FE00);
    @(posedge clk_i);
    chk(pad_oe[15:9], bio_oe);
    chk(pad_out[15:9] & bio_oe, bio_out & bio_oe);
    repeat (6) @(posedge clk_i);
    chk(bio_pin, 7'h2A);
    complete_run();
  end
endmodule // spfs_top_test
